// ### hdl/pcm_port_pkg.sv
// ============================================================
// Shared constants and types of the serial PCM port.
package pcm_port_pkg;

    // Frame sync rises that must be seen before the transmit driver may turn on.
    localparam logic [1:0] GUARD_SYNCS = 2'h2;
    // Sync rises with the receive bit clock held high that select the link.
    localparam logic [1:0] LINK_HOLDS  = 2'h2;
    // Falling edges with sync high that mark a long sync pulse.
    localparam logic [1:0] LONG_FALLS  = 2'h2;
    // Index of the last bit of a word.
    localparam logic [4:0] LAST_BIT    = 5'h07;
    // Link clock edges after sync at which each slot starts.
    localparam logic [4:0] B1_START    = 5'h01;
    localparam logic [4:0] B2_START    = 5'h0B;

    // Milliwatt magnitudes (chord and step bits).
    localparam logic [6:0] MU_MAG_HI   = 7'h1E;
    localparam logic [6:0] MU_MAG_LO   = 7'h0B;
    localparam logic [6:0] A_MAG_HI    = 7'h34;
    localparam logic [6:0] A_MAG_LO    = 7'h21;

    // Framing format, Gray coded.
    typedef enum logic [1:0] {
        MODE_LONG  = 2'h0,
        MODE_SHORT = 2'h1,
        MODE_LINK  = 2'h3
    } mode_t;

    // Transmit sequencer states.
    typedef enum logic [1:0] {
        TX_IDLE = 2'h0,
        TX_ARM  = 2'h1,
        TX_DRV  = 2'h3
    } tx_state_t;

    // Receive sequencer states.
    typedef enum logic [1:0] {
        RX_IDLE  = 2'h0,
        RX_ARM   = 2'h1,
        RX_SHIFT = 2'h3,
        RX_DONE  = 2'h2
    } rx_state_t;

    // The five serial pins seen from the device.
    typedef struct packed {
        logic tx_frame_sync;
        logic tx_bit_clock;
        logic rx_frame_sync;
        logic rx_bit_clock;
        logic rx_serial_in;
    } pins_t;

endpackage

// ### hdl/pcm_serial_port.sv
`timescale 1ns/1ps
module pcm_serial_port (
    input  logic       mclk,             // System clock.
    input  logic       rst,              // Synchronous reset, active high.
    input  logic       power_down,       // Holds the port idle, driver off.
    input  logic       a_law_select,     // Milliwatt codes from the A-law set.
    input  logic       mw_select,        // Sends milliwatt codes, not tx_word.
    input  logic [7:0] tx_word,          // Word to send, taken at word start.
    input  logic       tx_frame_sync,    // Transmit frame sync pin.
    input  logic       tx_bit_clock,     // Transmit bit clock pin.
    input  logic       rx_frame_sync,    // Receive sync or slot select pin.
    input  logic       rx_bit_clock,     // Receive bit clock or mode pin.
    input  logic       rx_serial_in,     // Receive data pin.
    output logic       tx_serial_out,    // Transmit data pin level.
    output logic       tx_serial_out_en, // Transmit driver enable.
    output logic       tx_word_taken,    // Pulse after tx_word or a milliwatt code was loaded.
    output logic [7:0] rx_word,          // Last word received.
    output logic       rx_word_valid,    // Pulse when rx_word is new.
    output logic       interchip_link_mode, // Link framing is active.
    output logic       long_sync         // Long framing chosen.
);

    // ============================================================
    // Pin synchronisers and edge finders.
    pcm_port_pkg::pins_t pin_w;  // Raw pins.
    pcm_port_pkg::pins_t s1_q;   // First stage, read only by s2_q.
    pcm_port_pkg::pins_t s2_q;   // Settled levels.
    pcm_port_pkg::pins_t s3_q;   // Levels one cycle older.
    pcm_port_pkg::pins_t rise_w; // Rising edges.
    pcm_port_pkg::pins_t fall_w; // Falling edges.

    assign pin_w  = {tx_frame_sync, tx_bit_clock, rx_frame_sync, rx_bit_clock, rx_serial_in};
    assign rise_w = s2_q & ~s3_q;
    assign fall_w = ~s2_q & s3_q;

    // Two flops per pin, a third for edge finding.
    always_ff @(posedge mclk) begin
        if (rst) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else begin
            s1_q <= pin_w;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    logic tfs;    // Transmit sync level.
    logic tfs_r;  // Transmit sync rising.
    logic tclk;   // Transmit clock level.
    logic tclk_r; // Transmit clock rising.
    logic tclk_f; // Transmit clock falling.
    assign tfs    = s2_q.tx_frame_sync;
    assign tfs_r  = rise_w.tx_frame_sync;
    assign tclk   = s2_q.tx_bit_clock;
    assign tclk_r = rise_w.tx_bit_clock;
    assign tclk_f = fall_w.tx_bit_clock;

    // ============================================================
    // Format detection and power-up guard.
    logic [1:0] fs_hi_q, fs_hi_d; // Falls seen with sync high.
    logic       long_q, long_d;   // Format for the next frame.
    logic [1:0] lk_q, lk_d;       // Sync rises with receive clock still high.
    logic [1:0] guard_q, guard_d; // Syncs seen since power-up.
    pcm_port_pkg::mode_t mode_w;  // Framing now in force.
    logic       ready_w;          // Driver may turn on.

    // Counts sync samples, clock holds and guard syncs.
    always_comb begin
        fs_hi_d = fs_hi_q;
        long_d  = long_q;
        lk_d    = lk_q;
        guard_d = guard_q;
        if (tclk_f) begin
            if (tfs) begin
                if (fs_hi_q != pcm_port_pkg::LONG_FALLS) begin
                    fs_hi_d = fs_hi_q + 2'h1;
                end
            end else begin
                // Pulse over: classify it for the next frame.
                if (fs_hi_q != 2'h0) begin
                    long_d = (fs_hi_q == pcm_port_pkg::LONG_FALLS);
                end
                fs_hi_d = 2'h0;
            end
        end
        // A moving receive clock cancels the link selection.
        if (rise_w.rx_bit_clock || fall_w.rx_bit_clock) begin
            lk_d = 2'h0;
        end else if (tfs_r && s2_q.rx_bit_clock && lk_q != pcm_port_pkg::LINK_HOLDS) begin
            lk_d = lk_q + 2'h1;
        end
        // Guard restarts at every power-down.
        if (power_down) begin
            guard_d = 2'h0;
        end else if (tfs_r && guard_q != pcm_port_pkg::GUARD_SYNCS) begin
            guard_d = guard_q + 2'h1;
        end
    end

    // Registers the detection state.
    always_ff @(posedge mclk) begin
        if (rst) begin
            fs_hi_q <= 2'h0;
            long_q  <= 1'b1;
            lk_q    <= 2'h0;
            guard_q <= 2'h0;
        end else begin
            fs_hi_q <= fs_hi_d;
            long_q  <= long_d;
            lk_q    <= lk_d;
            guard_q <= guard_d;
        end
    end

    assign mode_w  = (lk_q == pcm_port_pkg::LINK_HOLDS) ? pcm_port_pkg::MODE_LINK :
                     (long_q ? pcm_port_pkg::MODE_LONG : pcm_port_pkg::MODE_SHORT);
    assign ready_w = (guard_q == pcm_port_pkg::GUARD_SYNCS) && !power_down;

    // Slot start edge from the slot select pin.
    logic [4:0] slot_w;
    assign slot_w = s2_q.rx_frame_sync ? pcm_port_pkg::B2_START : pcm_port_pkg::B1_START;

    // Milliwatt code for a phase: sign, then magnitude.
    function automatic logic [7:0] mw_code(input logic [2:0] ph, input logic a_law);
        logic       hi;
        logic [6:0] mag;
        hi  = (ph[1:0] == 2'h0) || (ph[1:0] == 2'h3);
        mag = a_law ? (hi ? pcm_port_pkg::A_MAG_HI : pcm_port_pkg::A_MAG_LO)
                    : (hi ? pcm_port_pkg::MU_MAG_HI : pcm_port_pkg::MU_MAG_LO);
        return {ph[2], mag};
    endfunction

    // ============================================================
    // Transmit sequencer.
    pcm_port_pkg::tx_state_t tx_q, tx_d; // Sequencer state.
    logic [4:0] tc_q, tc_d;   // Clock edges since sync or word start.
    logic       half_q, half_d; // Mid last bit passed, long sync still high.
    logic [7:0] sh_q, sh_d;   // Outgoing word, MSB on the pin.
    logic       oe_q, oe_d;   // Driver enable.
    logic [2:0] ph_q, ph_d;   // Milliwatt phase.
    logic       tk_q, tk_d;   // Word taken pulse.
    logic       load_w;       // Start a word this cycle.

    // Next state of the transmit side.
    always_comb begin
        tx_d   = tx_q;
        tc_d   = tc_q;
        half_d = half_q;
        sh_d   = sh_q;
        oe_d   = oe_q;
        ph_d   = ph_q;
        tk_d   = 1'b0;
        load_w = 1'b0;
        unique case (tx_q)
            pcm_port_pkg::TX_IDLE: begin
                if (mode_w == pcm_port_pkg::MODE_LONG) begin
                    load_w = tfs && tclk && ready_w;
                end else if (tclk_f && tfs && ready_w) begin
                    tx_d = pcm_port_pkg::TX_ARM;
                    tc_d = 5'h00;
                end
            end
            pcm_port_pkg::TX_ARM: begin
                if (tclk_r) begin
                    if (mode_w == pcm_port_pkg::MODE_LINK) begin
                        tc_d   = tc_q + 5'h01;
                        load_w = (tc_q + 5'h01) == slot_w;
                    end else begin
                        load_w = 1'b1;
                    end
                end
            end
            pcm_port_pkg::TX_DRV: begin
                if (tclk_r && tc_q != pcm_port_pkg::LAST_BIT) begin
                    tc_d = tc_q + 5'h01;
                    sh_d = {sh_q[6:0], 1'b0};
                end
                if (tclk_f && tc_q == pcm_port_pkg::LAST_BIT) begin
                    if (mode_w == pcm_port_pkg::MODE_LONG && tfs) begin
                        half_d = 1'b1;
                    end else begin
                        tx_d = pcm_port_pkg::TX_IDLE;
                        oe_d = 1'b0;
                    end
                end
                if (half_q && !tfs) begin
                    tx_d = pcm_port_pkg::TX_IDLE;
                    oe_d = 1'b0;
                end
            end
        endcase
        if (load_w) begin
            tx_d   = pcm_port_pkg::TX_DRV;
            tc_d   = 5'h00;
            half_d = 1'b0;
            oe_d   = 1'b1;
            tk_d   = 1'b1;
            sh_d   = mw_select ? mw_code(ph_q, a_law_select) : tx_word;
            ph_d   = ph_q + {2'h0, mw_select};
        end
        if (power_down) begin
            tx_d = pcm_port_pkg::TX_IDLE;
            oe_d = 1'b0;
        end
    end

    // Registers the transmit side.
    always_ff @(posedge mclk) begin
        if (rst) begin
            tx_q   <= pcm_port_pkg::TX_IDLE;
            tc_q   <= 5'h00;
            half_q <= 1'b0;
            sh_q   <= 8'h00;
            oe_q   <= 1'b0;
            ph_q   <= 3'h0;
            tk_q   <= 1'b0;
        end else begin
            tx_q   <= tx_d;
            tc_q   <= tc_d;
            half_q <= half_d;
            sh_q   <= sh_d;
            oe_q   <= oe_d;
            ph_q   <= ph_d;
            tk_q   <= tk_d;
        end
    end

    // ============================================================
    // Receive sequencer; the link uses the transmit pins.
    logic link_w; // Link framing in force.
    logic rc_r;   // Receive timing clock rising.
    logic rc_f;   // Receive timing clock falling.
    logic rc;     // Receive bit clock pin level, in every mode.
    logic rs;     // Receive timing sync level.
    assign link_w = (mode_w == pcm_port_pkg::MODE_LINK);
    assign rc_r   = link_w ? tclk_r : rise_w.rx_bit_clock;
    assign rc_f   = link_w ? tclk_f : fall_w.rx_bit_clock;
    assign rc     = s2_q.rx_bit_clock;
    assign rs     = link_w ? tfs : s2_q.rx_frame_sync;

    pcm_port_pkg::rx_state_t rx_q, rx_d; // Sequencer state.
    logic [4:0] rcnt_q, rcnt_d; // Edges since sync or bits taken.
    logic [7:0] rsh_q, rsh_d;   // Incoming word.
    logic [7:0] rw_q, rw_d;     // Handed over word.
    logic       rv_q, rv_d;     // Hand-over pulse.
    logic       blk_q, blk_d;   // Long sync still high after a word.

    // Next state of the receive side.
    always_comb begin
        rx_d   = rx_q;
        rcnt_d = rcnt_q;
        rsh_d  = rsh_q;
        rw_d   = rw_q;
        rv_d   = 1'b0;
        blk_d  = blk_q && rs;
        unique case (rx_q)
            pcm_port_pkg::RX_IDLE: begin
                rcnt_d = 5'h00;
                if (link_w) begin
                    if (rc_f && rs) begin
                        rx_d = pcm_port_pkg::RX_ARM;
                    end
                end else if (mode_w == pcm_port_pkg::MODE_LONG) begin
                    if (rs && rc && !blk_q) begin
                        rx_d = pcm_port_pkg::RX_SHIFT;
                    end
                end else if (rc_f && rs) begin
                    rx_d = pcm_port_pkg::RX_SHIFT;
                end
            end
            pcm_port_pkg::RX_ARM: begin
                if (rc_f) begin
                    rcnt_d = rcnt_q + 5'h01;
                    if ((rcnt_q + 5'h01) == slot_w) begin
                        rsh_d  = {rsh_q[6:0], s2_q.rx_serial_in};
                        rcnt_d = 5'h01;
                        rx_d   = pcm_port_pkg::RX_SHIFT;
                    end
                end
            end
            pcm_port_pkg::RX_SHIFT: begin
                if (rc_f) begin
                    rsh_d  = {rsh_q[6:0], s2_q.rx_serial_in};
                    rcnt_d = rcnt_q + 5'h01;
                    if (rcnt_q == pcm_port_pkg::LAST_BIT) begin
                        rx_d = pcm_port_pkg::RX_DONE;
                    end
                end
            end
            pcm_port_pkg::RX_DONE: begin
                if (rc_r) begin
                    rw_d  = rsh_q;
                    rv_d  = 1'b1;
                    blk_d = rs;
                    rx_d  = pcm_port_pkg::RX_IDLE;
                end
            end
        endcase
        if (power_down) begin
            rx_d = pcm_port_pkg::RX_IDLE;
        end
    end

    // Registers the receive side.
    always_ff @(posedge mclk) begin
        if (rst) begin
            rx_q   <= pcm_port_pkg::RX_IDLE;
            rcnt_q <= 5'h00;
            rsh_q  <= 8'h00;
            rw_q   <= 8'h00;
            rv_q   <= 1'b0;
            blk_q  <= 1'b0;
        end else begin
            rx_q   <= rx_d;
            rcnt_q <= rcnt_d;
            rsh_q  <= rsh_d;
            rw_q   <= rw_d;
            rv_q   <= rv_d;
            blk_q  <= blk_d;
        end
    end

    assign tx_serial_out       = sh_q[7];
    assign tx_serial_out_en    = oe_q;
    assign tx_word_taken       = tk_q;
    assign rx_word             = rw_q;
    assign rx_word_valid       = rv_q;
    assign interchip_link_mode = link_w;
    assign long_sync           = long_q;

    // ============================================================
    // Checks.
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    sequence data_load_s;
        tx_word_taken && !$past(mw_select);
    endsequence
    sequence mw_load_s;
        tx_word_taken && $past(mw_select);
    endsequence

    a_guard_driver_off: assert property (guard_q != 2'h2 |-> !tx_serial_out_en)
        else $error("driver on before guard syncs");
    a_long_drive_on: assert property (
        tx_q == pcm_port_pkg::TX_IDLE && mode_w == pcm_port_pkg::MODE_LONG
        && tfs && tclk && ready_w |=> tx_serial_out_en)
        else $error("long sync driver not enabled");
    a_long_drive_hold: assert property (
        tx_serial_out_en && mode_w == pcm_port_pkg::MODE_LONG
        && tfs && !power_down |=> tx_serial_out_en)
        else $error("long sync driver dropped early");
    a_class_long: assert property (fs_hi_q == 2'h2 && tclk_f && !tfs |=> long_sync)
        else $error("long pulse not classed long");
    a_class_short: assert property (fs_hi_q == 2'h1 && tclk_f && !tfs |=> !long_sync)
        else $error("short pulse not classed short");
    a_short_start: assert property (
        tx_q == pcm_port_pkg::TX_ARM && mode_w == pcm_port_pkg::MODE_SHORT
        && tclk_r && !power_down |=> tx_serial_out_en)
        else $error("short sync driver not enabled");
    a_rx_eight_bits: assert property (
        rx_q == pcm_port_pkg::RX_SHIFT && rc_f && rcnt_q == pcm_port_pkg::LAST_BIT
        && !power_down |=> rx_q == pcm_port_pkg::RX_DONE)
        else $error("word not complete after eight bits");
    a_rx_hand_over: assert property (
        rx_q == pcm_port_pkg::RX_DONE && rc_r && !power_down
        |=> rx_word_valid && rx_word == $past(rsh_q))
        else $error("word not handed over on rise");
    a_link_enter: assert property (
        tfs_r && s2_q.rx_bit_clock && lk_q == 2'h1
        && !rise_w.rx_bit_clock && !fall_w.rx_bit_clock |=> interchip_link_mode)
        else $error("link mode not entered");
    a_link_slot_only: assert property (
        interchip_link_mode && tx_serial_out_en |-> tx_q == pcm_port_pkg::TX_DRV)
        else $error("link driver on outside word");
    a_msb_first: assert property (data_load_s |-> tx_serial_out == $past(tx_word[7]))
        else $error("word not sent sign bit first");
    a_mw_sign: assert property (mw_load_s |-> tx_serial_out == $past(ph_q[2]))
        else $error("milliwatt sign wrong for phase");

endmodule // pcm_serial_port

// ### sim/pcm_highway_model.sv
`timescale 1ns/1ps
// ==========================================
// Far-side model: a highway switch that makes clocks, syncs and receive data.
module pcm_highway_model (
    output logic      tx_frame_sync,    // Transmit sync or link sync.
    output logic      tx_bit_clock,     // Transmit bit clock or link clock.
    output logic      rx_frame_sync,    // Receive sync or slot select.
    output logic      rx_bit_clock,     // Receive bit clock or mode pin.
    output logic      rx_serial_in,     // Receive data line.
    input  wire logic tx_serial_out,    // Device data level.
    input  wire logic tx_serial_out_en  // Device driver enable.
);
    // All lines start low; clocks stand still outside frames.
    initial begin
        {tx_frame_sync, tx_bit_clock, rx_frame_sync, rx_bit_clock, rx_serial_in} = 5'h00;
    end

    // One frame: mode 0 long, 1 short, 2 link. Bit period is 160 ns.
    task automatic frame(input int mode, input logic slot, input logic [7:0] rxd,
                         output logic [7:0] txd, output int en_in, output int en_out);
        int first;
        int total;
        first = (mode == 0) ? 0 : ((mode == 1 || !slot) ? 1 : 11);
        total = (mode == 2) ? 20 : 10;
        txd = 8'h00;
        en_in = 0;
        en_out = 0;
        rx_bit_clock = (mode == 2);
        rx_frame_sync = (mode == 2) ? slot : 1'b0;
        for (int c = 0; c < total; c++) begin
            // Rising half: sync and data change with the clock rise.
            tx_bit_clock = 1'b1;
            tx_frame_sync = (mode == 0) ? (c < 8) : (c == 0);
            if (mode != 2) begin
                rx_bit_clock = 1'b1;
                rx_frame_sync = tx_frame_sync;
            end
            if (c >= first && c < first + 8) begin
                rx_serial_in = rxd[7 - (c - first)];
            end else begin
                rx_serial_in = ~rx_serial_in; // Released line changes every cycle.
            end
            #80;
            tx_bit_clock = 1'b0;
            if (mode != 2) begin
                rx_bit_clock = 1'b0;
            end
            // Sample a little after the fall so the registered outputs settle.
            #30;
            if (tx_serial_out_en === 1'b1 && c >= first && c < first + 8) begin
                txd[7 - (c - first)] = tx_serial_out;
                en_in++;
            end else if (tx_serial_out_en === 1'b1) begin
                en_out++;
            end
            #50;
        end
        tx_frame_sync = 1'b0;
    endtask
endmodule // pcm_highway_model

// ### sim/pcm_serial_port_timing_bench.sv
`timescale 1ns/1ps
// ==========================================
// Self-checking bench of the serial PCM port.
module pcm_serial_port_timing_bench;
    logic       mclk = 1'b0;          // System clock, 50 MHz.
    logic       rst = 1'b1;           // Synchronous reset.
    logic       power_down = 1'b0;    // Port idle request.
    logic       a_law_select = 1'b0;  // Milliwatt code set.
    logic       mw_select = 1'b0;     // Milliwatt source select.
    logic [7:0] tx_word = 8'h00;      // Word to send.
    logic       tx_frame_sync, tx_bit_clock, rx_frame_sync, rx_bit_clock, rx_serial_in;
    logic       tx_serial_out, tx_serial_out_en, tx_word_taken, rx_word_valid;
    logic       interchip_link_mode, long_sync;
    logic [7:0] rx_word;              // Received word.
    logic [7:0] got_rx = 8'h00;       // Last word seen with its valid pulse.
    logic [7:0] seed = 8'h0B;         // Random state.
    int         n_rx = 0;             // Valid pulses seen.
    int         n_tk = 0;             // Word taken pulses seen.
    int         bad_count = 0;        // Mismatches.
    int         num_checks = 0;       // Comparisons.
    int         cyc = 0;              // Cycle count for the hang limit.
    int         drv;                  // Driven samples of the last frame.

    pcm_serial_port dut_u (.mclk(mclk), .rst(rst), .power_down(power_down),
        .a_law_select(a_law_select), .mw_select(mw_select), .tx_word(tx_word),
        .tx_frame_sync(tx_frame_sync), .tx_bit_clock(tx_bit_clock),
        .rx_frame_sync(rx_frame_sync), .rx_bit_clock(rx_bit_clock),
        .rx_serial_in(rx_serial_in), .tx_serial_out(tx_serial_out),
        .tx_serial_out_en(tx_serial_out_en), .tx_word_taken(tx_word_taken),
        .rx_word(rx_word), .rx_word_valid(rx_word_valid),
        .interchip_link_mode(interchip_link_mode), .long_sync(long_sync));
    pcm_highway_model partner_u (.tx_frame_sync(tx_frame_sync),
        .tx_bit_clock(tx_bit_clock), .rx_frame_sync(rx_frame_sync),
        .rx_bit_clock(rx_bit_clock), .rx_serial_in(rx_serial_in),
        .tx_serial_out(tx_serial_out), .tx_serial_out_en(tx_serial_out_en));

    // Clock, valid pulse recorder and hang limit.
    initial begin
        forever #10 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (rx_word_valid === 1'b1) begin
            got_rx <= rx_word;
            n_rx <= n_rx + 1;
        end
        if (tx_word_taken === 1'b1) begin
            n_tk <= n_tk + 1;
        end
        if (cyc == 40000) begin
            bad_count++;
            conclude();
        end
    end

    // Next random byte from an 8-bit shift register.
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    // Milliwatt code of one phase: sign set for phases 4..7.
    function automatic logic [7:0] mw_exp(input int p, input logic al);
        logic hi;
        hi = (p == 0 || p == 3 || p == 4 || p == 7);
        return {(p > 3), al ? (hi ? 7'h34 : 7'h21) : (hi ? 7'h1E : 7'h0B)};
    endfunction
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            $display("ERROR %s expected %h seen %h", what, exp, got);
            bad_count++;
        end
    endtask
    task automatic setin(input logic pd, input logic al, input logic mw);
        @(posedge mclk);
        #2;
        {power_down, a_law_select, mw_select} = {pd, al, mw};
    endtask

    // One frame with a random receive word; checks are optional.
    task automatic xfer(input int mode, input logic slot, input logic use_exp,
                        input logic [7:0] exp, input logic check);
        logic [7:0] rxd;
        logic [7:0] txw;
        logic [7:0] txd;
        int ein;
        int eout;
        int n0;
        int t0;
        seed = lfsr(seed);
        rxd = seed;
        seed = lfsr(seed);
        txw = seed;
        @(posedge mclk);
        #2;
        tx_word = txw;
        n0 = n_rx;
        t0 = n_tk;
        partner_u.frame(mode, slot, rxd, txd, ein, eout);
        repeat (12) @(posedge mclk);
        drv = ein + eout;
        if (check) begin
            chk("tx_data", use_exp ? exp : txw, txd);
            chk("tx_driven_bits", 8'h08, 8'(ein));
            chk("tx_stray_drive", 8'h00, 8'(eout));
            chk("tx_taken", 8'h01, 8'(n_tk - t0));
            chk("rx_word", rxd, got_rx);
            chk("rx_count", 8'h01, 8'(n_rx - n0));
        end
    endtask

    // Verdict and end of run.
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Main sequence.
    initial begin
        repeat (2) @(posedge mclk);
        #2;
        rst = 1'b0;
        chk("en_reset", 8'h00, {7'h00, tx_serial_out_en});
        chk("long_reset", 8'h01, {7'h00, long_sync});
        xfer(0, 0, 0, 0, 0);
        chk("guard_drive", 8'h00, 8'(drv));
        xfer(0, 0, 0, 0, 0);
        for (int i = 0; i < 4; i++) xfer(0, 0, 0, 0, 1);
        chk("long_mode", 8'h01, {7'h00, long_sync});
        $display("TEST long_sync done");
        xfer(1, 0, 0, 0, 0);
        chk("short_mode", 8'h00, {7'h00, long_sync});
        for (int i = 0; i < 3; i++) xfer(1, 0, 0, 0, 1);
        $display("TEST short_sync done");
        for (int al = 0; al < 2; al++) begin
            setin(0, al[0], 1);
            for (int p = 0; p < 8; p++) xfer(1, 0, 1, mw_exp(p, al[0]), 1);
        end
        $display("TEST milliwatt done");
        setin(0, 0, 0);
        xfer(0, 0, 0, 0, 0);
        chk("long_again", 8'h01, {7'h00, long_sync});
        setin(1, 0, 0);
        xfer(0, 0, 0, 0, 0);
        chk("pd_drive", 8'h00, 8'(drv));
        setin(0, 0, 0);
        xfer(0, 0, 0, 0, 0);
        chk("pd_guard_drive", 8'h00, 8'(drv));
        xfer(0, 0, 0, 0, 0);
        xfer(0, 0, 0, 0, 1);
        $display("TEST power_down done");
        // The first link sync rises together with the receive clock, so it is not
        // a held level; two further sync rises are needed to select the link.
        xfer(2, 0, 0, 0, 0);
        xfer(2, 0, 0, 0, 0);
        xfer(2, 0, 0, 0, 0);
        chk("link_mode", 8'h01, {7'h00, interchip_link_mode});
        for (int i = 0; i < 4; i++) xfer(2, i[0], 0, 0, 1);
        $display("TEST link done");
        conclude();
    end
endmodule // pcm_serial_port_timing_bench
